// ---- verilog/ccr_pkg.sv ----
package ccr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] CCR_ADDR_LOAD = 8'h07;
  localparam logic [7:0] CCR_ADDR_TEMP = 8'h08;
  localparam logic [7:0] CCR_ADDR_OTP_ONLY = 8'h0a;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CCR_LOAD_RST = 8'h13;
  localparam logic [7:0] CCR_TEMP_RST = 8'hee;
  localparam logic [1:0] CCR_NOLOAD_RST = 2'h0;
  localparam logic [1:0] CCR_IPK_RST = 2'h3;
  // Regulation voltage code until the one-time store is read
  localparam logic [2:0] CCR_VREG_RST = 3'h4;

  // ==========================================================
  // One-time store field positions
  localparam int CCR_OTP_VREG_HI = 6;
  localparam int CCR_OTP_VREG_LO = 4;
  localparam int CCR_OTP_NOLOAD_HI = 7;
  localparam int CCR_OTP_NOLOAD_LO = 6;
  localparam int CCR_OTP_STOP_BIT = 4;
  localparam int CCR_OTP_VIN_BIT = 3;
  localparam int CCR_OTP_TMR_BIT = 7;
  localparam int CCR_OTP_PRE_BIT = 3;

  // ==========================================================
  // Thermistor zone codes and voltage reduction codes
  localparam logic [2:0] CCR_ZONE_NORMAL = 3'h0;
  localparam logic [2:0] CCR_ZONE_WARM = 3'h1;
  localparam logic [2:0] CCR_ZONE_COOL = 3'h2;
  localparam logic [2:0] CCR_ZONE_COLD = 3'h3;
  localparam logic [2:0] CCR_ZONE_HOT = 3'h4;
  localparam logic [1:0] CCR_REDUCE_NONE = 2'h0;
  localparam logic [1:0] CCR_REDUCE_100MV = 2'h1;
  localparam logic [1:0] CCR_REDUCE_200MV = 2'h2;
  localparam logic [7:0] CCR_READ_ZERO = 8'h00;

  // ==========================================================
  // Register layouts, msb first
  typedef struct packed {
    logic [1:0] no_load_threshold;
    logic battery_overvoltage_flag;
    logic temp_window_stop;
    logic input_overvoltage_level;
    logic switching_frequency_select;
    logic [1:0] boost_peak_current_limit;
  } ccr_load_cfg_s;

  typedef struct packed {
    logic temp_voltage_reduction;
    logic temp_current_reduction;
    logic hot_threshold;
    logic [1:0] warm_threshold;
    logic [1:0] cool_threshold;
    logic cold_threshold;
  } ccr_temp_cfg_s;

  typedef struct packed {
    logic [2:0] charge_regulation_voltage;
    logic [1:0] no_load_threshold;
    logic temp_window_stop;
    logic input_overvoltage_level;
    logic safety_timer_select;
    logic precharge_threshold_select;
  } ccr_otp_s;

  localparam ccr_otp_s CCR_OTP_RST = '{CCR_VREG_RST, CCR_NOLOAD_RST, 1'b1, 1'b0, 1'b0, 1'b0};

  typedef enum logic [1:0] {
    CCR_LD_CAPTURE,
    CCR_LD_APPLY,
    CCR_LD_DONE
  } ccr_ld_state_e;

endpackage : ccr_pkg

// ---- verilog/ccr_otp_loader.sv ----
`timescale 1ns/10ps
module ccr_otp_loader (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // One-time store words
  input wire logic [7:0] otp_word_02,
  input wire logic [7:0] otp_word_07,
  input wire logic [7:0] otp_word_0a,
  // Reload request from register reset
  input wire logic reload,
  // Decoded values and apply strobe
  output ccr_pkg::ccr_otp_s otp_vals,
  output logic otp_apply
);
  import ccr_pkg::*;

  ccr_ld_state_e state_ff;
  ccr_otp_s otp_ff;

  // ==========================================================
  // Sequencing: capture once after release, then apply; apply again on each reload seen in DONE
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= CCR_LD_CAPTURE;
    end else begin
      case (state_ff)
        CCR_LD_CAPTURE: state_ff <= CCR_LD_APPLY;
        CCR_LD_APPLY: state_ff <= CCR_LD_DONE;
        CCR_LD_DONE: state_ff <= reload ? CCR_LD_APPLY : CCR_LD_DONE;
        default: state_ff <= CCR_LD_CAPTURE;
      endcase
    end
  end

  // ==========================================================
  // Store is read once; register reset never touches it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      otp_ff <= CCR_OTP_RST;
    end else if (state_ff == CCR_LD_CAPTURE) begin
      otp_ff.charge_regulation_voltage <= otp_word_02[CCR_OTP_VREG_HI:CCR_OTP_VREG_LO];
      otp_ff.no_load_threshold <= otp_word_07[CCR_OTP_NOLOAD_HI:CCR_OTP_NOLOAD_LO];
      otp_ff.temp_window_stop <= otp_word_07[CCR_OTP_STOP_BIT];
      otp_ff.input_overvoltage_level <= otp_word_07[CCR_OTP_VIN_BIT];
      otp_ff.safety_timer_select <= otp_word_0a[CCR_OTP_TMR_BIT];
      otp_ff.precharge_threshold_select <= otp_word_0a[CCR_OTP_PRE_BIT];
    end
  end

  assign otp_vals = otp_ff;
  assign otp_apply = (state_ff == CCR_LD_APPLY);

endmodule : ccr_otp_loader

// ---- verilog/ccr_config_regs.sv ----
`timescale 1ns/10ps
module ccr_config_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register access, decoded from the serial bus
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rst_req,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  // One-time store words
  input wire logic [7:0] otp_word_02,
  input wire logic [7:0] otp_word_07,
  input wire logic [7:0] otp_word_0a,
  // Analog status inputs
  input wire logic battery_overvoltage_flag_in,
  input wire logic [2:0] temp_zone_in,
  // Configuration to the analog core
  output ccr_pkg::ccr_load_cfg_s cfg_load_ff,
  output ccr_pkg::ccr_temp_cfg_s cfg_temp_ff,
  output ccr_pkg::ccr_otp_s otp_cfg_ff,
  // Temperature control
  output logic [2:0] temp_status_ff,
  output logic charge_suspend_ff,
  output logic boost_suspend_ff,
  output logic [1:0] vreg_reduce_ff
);
  import ccr_pkg::*;

  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic ovp_sync;
  logic [2:0] zone_sync;
  logic out_of_window;
  logic warm_or_cool;
  logic wr_load;
  logic wr_temp;
  logic otp_apply;
  ccr_otp_s otp_vals;
  logic [2:0] zone_prev_ff;
  logic [2:0] zone_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= {battery_overvoltage_flag_in, temp_zone_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign ovp_sync = sync2_ff[3];
  // Zone taken only once two samples agree; hides codes caught mid-change
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      zone_prev_ff <= CCR_ZONE_NORMAL;
      zone_ff <= CCR_ZONE_NORMAL;
    end else begin
      zone_prev_ff <= sync2_ff[2:0];
      if (sync2_ff[2:0] == zone_prev_ff) begin
        zone_ff <= zone_prev_ff;
      end
    end
  end

  assign zone_sync = zone_ff;
  assign out_of_window = (zone_sync == CCR_ZONE_HOT) || (zone_sync == CCR_ZONE_COLD);
  assign warm_or_cool = (zone_sync == CCR_ZONE_WARM) || (zone_sync == CCR_ZONE_COOL);
  assign wr_load = reg_wr && (reg_addr == CCR_ADDR_LOAD);
  assign wr_temp = reg_wr && (reg_addr == CCR_ADDR_TEMP);

  // ==========================================================
  // One-time store loader
  ccr_otp_loader u_otp_loader (
    .ref_clk(ref_clk),
    .reset(reset),
    .otp_word_02(otp_word_02),
    .otp_word_07(otp_word_07),
    .otp_word_0a(otp_word_0a),
    .reload(reg_rst_req),
    .otp_vals(otp_vals),
    .otp_apply(otp_apply)
  );

  // ==========================================================
  // Load and protection register
  always_ff @(posedge ref_clk) begin
    if (reset || reg_rst_req) begin
      cfg_load_ff <= CCR_LOAD_RST;
    end else begin
      if (otp_apply) begin
        cfg_load_ff.no_load_threshold <= otp_vals.no_load_threshold;
        cfg_load_ff.temp_window_stop <= otp_vals.temp_window_stop;
        cfg_load_ff.input_overvoltage_level <= otp_vals.input_overvoltage_level;
      end
      if (wr_load) begin
        cfg_load_ff.no_load_threshold <= reg_wdata[7:6];
        cfg_load_ff.temp_window_stop <= reg_wdata[4];
        cfg_load_ff.input_overvoltage_level <= reg_wdata[3];
        cfg_load_ff.switching_frequency_select <= reg_wdata[2];
        cfg_load_ff.boost_peak_current_limit <= reg_wdata[1:0];
      end
      // Flag follows the comparator; writes cannot touch it
      cfg_load_ff.battery_overvoltage_flag <= ovp_sync;
    end
  end

  // ==========================================================
  // Temperature profile register
  always_ff @(posedge ref_clk) begin
    if (reset || reg_rst_req) begin
      cfg_temp_ff <= CCR_TEMP_RST;
    end else if (wr_temp) begin
      cfg_temp_ff <= reg_wdata;
    end
  end

  // ==========================================================
  // One-time values held for the core
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      otp_cfg_ff <= CCR_OTP_RST;
    end else if (otp_apply) begin
      otp_cfg_ff <= otp_vals;
    end
  end

  // ==========================================================
  // Read port; hidden and unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_ff <= CCR_READ_ZERO;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          CCR_ADDR_LOAD: reg_rdata_ff <= cfg_load_ff;
          CCR_ADDR_TEMP: reg_rdata_ff <= cfg_temp_ff;
          default: reg_rdata_ff <= CCR_READ_ZERO;
        endcase
      end
    end
  end

  // ==========================================================
  // Thermistor window handling
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      temp_status_ff <= CCR_ZONE_NORMAL;
      charge_suspend_ff <= 1'b0;
      boost_suspend_ff <= 1'b0;
    end else begin
      temp_status_ff <= zone_sync;
      charge_suspend_ff <= cfg_load_ff.temp_window_stop && out_of_window;
      boost_suspend_ff <= cfg_load_ff.temp_window_stop && out_of_window;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vreg_reduce_ff <= CCR_REDUCE_NONE;
    end else if (!warm_or_cool) begin
      vreg_reduce_ff <= CCR_REDUCE_NONE;
    end else begin
      vreg_reduce_ff <= cfg_temp_ff.temp_voltage_reduction ? CCR_REDUCE_200MV
                                                           : CCR_REDUCE_100MV;
    end
  end

  // ==========================================================
  // Checks

  chk_noload_reset: assert property (
    reg_rst_req |=> cfg_load_ff.no_load_threshold == CCR_NOLOAD_RST
      && cfg_load_ff.boost_peak_current_limit == CCR_IPK_RST)
    else $error("register reset did not restore load fields");

  chk_stop_suspends: assert property (
    cfg_load_ff.temp_window_stop && out_of_window |=> charge_suspend_ff && boost_suspend_ff)
    else $error("out of window with stop set did not suspend");

  chk_report_only: assert property (
    !cfg_load_ff.temp_window_stop |=> !charge_suspend_ff && !boost_suspend_ff
      && temp_status_ff == $past(zone_sync))
    else $error("report only mode suspended or misreported");

  chk_ipk_write: assert property (
    wr_load && !reg_rst_req |=> cfg_load_ff.boost_peak_current_limit == $past(reg_wdata[1:0])
      && cfg_load_ff.no_load_threshold == $past(reg_wdata[7:6]))
    else $error("load register write not stored");

  chk_vreg_reduce: assert property (
    warm_or_cool |=> vreg_reduce_ff == ($past(cfg_temp_ff.temp_voltage_reduction)
      ? CCR_REDUCE_200MV : CCR_REDUCE_100MV))
    else $error("wrong regulation reduction in warm or cool");

  chk_timer_stable: assert property (
    reg_rst_req |=> $stable(otp_cfg_ff.safety_timer_select)
      ##1 $stable(otp_cfg_ff.safety_timer_select))
    else $error("timer select changed across register reset");

  chk_precharge_hold: assert property (
    !otp_apply |=> $stable(otp_cfg_ff.precharge_threshold_select))
    else $error("precharge select changed without store apply");

  chk_otp_hidden: assert property (
    reg_rd && reg_addr == CCR_ADDR_OTP_ONLY |=> reg_rvalid_ff && reg_rdata_ff == CCR_READ_ZERO)
    else $error("one-time location visible to host");

  chk_vreg_load: assert property (
    otp_apply |=> otp_cfg_ff.charge_regulation_voltage == $past(otp_vals.charge_regulation_voltage))
    else $error("regulation code not taken from store");

  chk_temp_readback: assert property (
    wr_temp && !reg_rst_req ##1 (reg_rd && reg_addr == CCR_ADDR_TEMP && !reg_rst_req && !reg_wr)
      |=> reg_rdata_ff == $past(reg_wdata, 2))
    else $error("temperature register readback mismatch");

  chk_ovp_flag: assert property (
    !reg_rst_req |=> cfg_load_ff.battery_overvoltage_flag == $past(ovp_sync))
    else $error("battery overvoltage flag not tracking input");

endmodule : ccr_config_regs

// ---- dv/ccr_host_model.sv ----
`timescale 1ns/10ps
module ccr_host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_rst_req,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_rst_req = 1'b0;
  end

  // ==========================================================
  // Bus cycles; released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    q = {reg_rvalid_ff, reg_rdata_ff};
  endtask : rd

  // Write then read of one offset, back to back
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [8:0] q);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    q = {reg_rvalid_ff, reg_rdata_ff};
  endtask : wrrd

  task automatic rst_pulse();
    @(negedge ref_clk);
    reg_rst_req = 1'b1;
    @(negedge ref_clk);
    reg_rst_req = 1'b0;
  endtask : rst_pulse
endmodule : ccr_host_model

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import ccr_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } ccr_row_s;

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic battery_overvoltage_flag_in = 1'b0;
  logic [2:0] temp_zone_in = 3'h0;
  logic [7:0] otp_w02 = 8'h50;
  logic [7:0] otp_w07 = 8'h88;
  logic [7:0] otp_w0a = 8'h88;
  logic [8:0] rq;
  logic reg_wr, reg_rd, reg_rst_req, reg_rvalid_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff;
  ccr_load_cfg_s cfg_load_ff;
  ccr_temp_cfg_s cfg_temp_ff;
  ccr_otp_s otp_cfg_ff;
  logic [2:0] temp_status_ff;
  logic charge_suspend_ff, boost_suspend_ff;
  logic [1:0] vreg_reduce_ff;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  ccr_row_s rows [9] = '{
    '{8'h07, 8'h00, 8'h00}, '{8'h07, 8'h41, 8'h41}, '{8'h07, 8'h82, 8'h82},
    '{8'h07, 8'hff, 8'hdf}, '{8'h08, 8'h00, 8'h00}, '{8'h08, 8'hff, 8'hff},
    '{8'h08, 8'h5a, 8'h5a}, '{8'h0a, 8'hff, 8'h00}, '{8'h05, 8'hff, 8'h00}};

  always #20 ref_clk = ~ref_clk;

  ccr_host_model i_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rst_req(reg_rst_req),
    .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff));

  ccr_config_regs i_dut (.ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rst_req(reg_rst_req), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .otp_word_02(otp_w02), .otp_word_07(otp_w07), .otp_word_0a(otp_w0a),
    .battery_overvoltage_flag_in(battery_overvoltage_flag_in), .temp_zone_in(temp_zone_in), .cfg_load_ff(cfg_load_ff),
    .cfg_temp_ff(cfg_temp_ff), .otp_cfg_ff(otp_cfg_ff), .temp_status_ff(temp_status_ff),
    .charge_suspend_ff(charge_suspend_ff), .boost_suspend_ff(boost_suspend_ff),
    .vreg_reduce_ff(vreg_reduce_ff));

  // ==========================================================
  // Checking and closing
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [8:0] q;
    i_host.rd(a, q);
    chk(q, {1'b1, e});
  endtask : rdchk

  // Status, suspends and reduction after the zone settles
  task automatic tz(input logic [7:0] l, input logic [7:0] t, input logic [2:0] z,
                    input logic [6:0] e);
    i_host.wr(CCR_ADDR_LOAD, l);
    i_host.wr(CCR_ADDR_TEMP, t);
    temp_zone_in = z;
    repeat (5) @(negedge ref_clk);
    chk({2'b00, temp_status_ff, charge_suspend_ff, boost_suspend_ff, vreg_reduce_ff},
        {2'b00, e});
    temp_zone_in = CCR_ZONE_NORMAL;
  endtask : tz

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    chk({1'b0, cfg_load_ff}, {1'b0, CCR_LOAD_RST});
    chk({1'b0, cfg_temp_ff}, {1'b0, CCR_TEMP_RST});
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(otp_cfg_ff, 9'h167);
    rdchk(CCR_ADDR_LOAD, 8'h8b);
    foreach (rows[i]) begin
      i_host.wrrd(rows[i].addr, rows[i].wdata, rq);
      chk(rq, {1'b1, rows[i].exp});
    end
    tz(8'h10, 8'hee, CCR_ZONE_HOT, {CCR_ZONE_HOT, 2'b11, CCR_REDUCE_NONE});
    tz(8'h10, 8'hee, CCR_ZONE_COLD, {CCR_ZONE_COLD, 2'b11, CCR_REDUCE_NONE});
    tz(8'h00, 8'hee, CCR_ZONE_HOT, {CCR_ZONE_HOT, 2'b00, CCR_REDUCE_NONE});
    tz(8'h00, 8'h6e, CCR_ZONE_WARM, {CCR_ZONE_WARM, 2'b00, CCR_REDUCE_100MV});
    tz(8'h10, 8'hee, CCR_ZONE_COOL, {CCR_ZONE_COOL, 2'b00, CCR_REDUCE_200MV});
    battery_overvoltage_flag_in = 1'b1;
    repeat (4) @(negedge ref_clk);
    rdchk(CCR_ADDR_LOAD, 8'h30);
    battery_overvoltage_flag_in = 1'b0;
    i_host.wr(CCR_ADDR_TEMP, 8'h11);
    i_host.wr(CCR_ADDR_LOAD, 8'h00);
    i_host.rst_pulse();
    repeat (3) @(negedge ref_clk);
    rdchk(CCR_ADDR_TEMP, CCR_TEMP_RST);
    rdchk(CCR_ADDR_LOAD, 8'h8b);
    chk(otp_cfg_ff, 9'h167);
    // Mid-run reset with other store words
    reset = 1'b1;
    otp_w02 = 8'h20;
    otp_w07 = 8'h50;
    otp_w0a = 8'h00;
    repeat (2) @(negedge ref_clk);
    chk(otp_cfg_ff, CCR_OTP_RST);
    chk({1'b0, cfg_load_ff}, {1'b0, CCR_LOAD_RST});
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(otp_cfg_ff, 9'h098);
    rdchk(CCR_ADDR_LOAD, 8'h53);
    otp_w0a = 8'h88;
    i_host.rst_pulse();
    repeat (3) @(negedge ref_clk);
    chk(otp_cfg_ff, 9'h098);
    finish_test();
  end
endmodule : tb_top
